//--- conv_ctrl.sv
// Control core of a fixed-frequency current-mode off-line converter.
module conv_ctrl #(
	parameter int unsigned SOFTSTART_CYC = conv_pkg::SOFTSTART_CYC,
	parameter int unsigned OVERLOAD_CYC = conv_pkg::OVERLOAD_CYC,
	parameter int unsigned RESTART_CYC = conv_pkg::RESTART_CYC,
	parameter int unsigned PERIOD_LOW = conv_pkg::PERIOD_LOW_CYC,
	parameter int unsigned PERIOD_HIGH = conv_pkg::PERIOD_HIGH_CYC,
	parameter int unsigned JIT_STEP = conv_pkg::JITTER_STEP_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Variant
	input wire logic high_freq_sel,
	input wire logic aux_winding_sel,
	// Comparators
	input wire conv_pkg::supply_cmp_t supply_cmp,
	input wire conv_pkg::loop_cmp_t loop_cmp,
	// Power stage
	output logic gate_drive,
	output logic charger_enable,
	output logic feedback_pullup_en,
	output logic burst_limit_sel,
	output logic [3:0] current_limit_level,
	// Status
	output conv_pkg::mode_t mode,
	output logic overload_stop
);

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	conv_pkg::supply_cmp_t sup;
	conv_pkg::loop_cmp_t lp;

	conv_sync #(.WIDTH(4)) u_sync_sup (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in(supply_cmp),
		.sync_out(sup)
	);

	conv_sync #(.WIDTH(6)) u_sync_loop (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in(loop_cmp),
		.sync_out(lp)
	);

	// ****************************************************************
	// Oscillator
	// ****************************************************************
	logic period_start;
	// Overload time is summed from the real period lengths, so the trip
	// time holds for both frequency variants.
	logic [9:0] period_len;

	conv_osc #(
		.PERIOD_LOW(PERIOD_LOW),
		.PERIOD_HIGH(PERIOD_HIGH),
		.JIT_STEP(JIT_STEP)
	) u_osc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.high_freq_sel(high_freq_sel),
		.period_start(period_start),
		.period_len(period_len)
	);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		conv_pkg::mode_t mode;
		logic gate;
		logic charger;
		logic [4:0] on_cnt;
		logic limit_hit;
		logic [31:0] ovl_cnt;
		logic [31:0] wait_cnt;
		logic [31:0] ss_cnt;
		logic [3:0] ss_level;
	} ctrl_state_t;

	ctrl_state_t st_r;
	ctrl_state_t st_nxt;
	logic blank_done;
	logic trip;
	logic limit_trip;
	logic run_mode;

	always_comb begin
		run_mode = (st_r.mode == conv_pkg::ST_RUN) ||
			(st_r.mode == conv_pkg::ST_BURST);
		blank_done = (st_r.on_cnt >= 5'(conv_pkg::MIN_ON_CYC));
		limit_trip = lp.overcurrent_comparator;
		trip = blank_done && (lp.pwm_trip || limit_trip);
		st_nxt = st_r;
		// Saturating keeps a long pulse from reopening the blanking window.
		if (!st_r.gate) begin
			st_nxt.on_cnt = 5'h00;
		end else if (st_r.on_cnt != 5'h1f) begin
			st_nxt.on_cnt = st_r.on_cnt + 5'h01;
		end
		// A hit in the period-start cycle wins and counts in the next period.
		if (st_r.gate && blank_done && limit_trip) begin
			st_nxt.limit_hit = 1'b1;
		end else if (period_start) begin
			st_nxt.limit_hit = 1'b0;
		end
		if (st_r.ss_cnt != 32'h0) begin
			st_nxt.ss_cnt = st_r.ss_cnt - 32'h1;
		end
		if (st_r.ss_cnt == 32'h1 || (st_r.ss_cnt != 32'h0 &&
			st_r.ss_cnt != 32'(SOFTSTART_CYC) &&
			st_r.ss_cnt % (SOFTSTART_CYC / conv_pkg::LIMIT_STEPS) == 32'h0 &&
			st_r.ss_level != conv_pkg::LIMIT_FULL)) begin
			st_nxt.ss_level = (st_r.ss_cnt == 32'h1) ?
				conv_pkg::LIMIT_FULL : st_r.ss_level + 4'h1;
		end
		unique case (st_r.mode)
			conv_pkg::ST_LOCKOUT: begin
				st_nxt.gate = 1'b0;
				if (sup.drain_start_level) begin
					st_nxt.charger = 1'b1;
				end
				if (sup.supply_start_level) begin
					st_nxt.mode = conv_pkg::ST_RUN;
					st_nxt.charger = 1'b0;
					st_nxt.ovl_cnt = '0;
					st_nxt.ss_cnt = 32'(SOFTSTART_CYC);
					st_nxt.ss_level = 4'h0;
				end
			end
			conv_pkg::ST_RESTART: begin
				st_nxt.gate = 1'b0;
				if (st_r.wait_cnt >= 32'(RESTART_CYC) - 32'h1) begin
					st_nxt.mode = conv_pkg::ST_RUN;
					st_nxt.ovl_cnt = '0;
					st_nxt.ss_cnt = 32'(SOFTSTART_CYC);
					st_nxt.ss_level = 4'h0;
				end else begin
					st_nxt.wait_cnt = st_r.wait_cnt + 32'h1;
				end
			end
			default: begin
				if (st_r.mode == conv_pkg::ST_RUN && !lp.burst_level) begin
					st_nxt.mode = conv_pkg::ST_BURST;
				end else if (st_r.mode == conv_pkg::ST_BURST &&
					lp.burst_hysteresis) begin
					st_nxt.mode = conv_pkg::ST_RUN;
				end
				if (period_start) begin
					if (st_r.limit_hit) begin
						st_nxt.ovl_cnt = st_r.ovl_cnt + 32'(period_len);
					end else if (st_r.ovl_cnt != 32'h0) begin
						st_nxt.ovl_cnt = (st_r.ovl_cnt > 32'(period_len)) ?
							st_r.ovl_cnt - 32'(period_len) : 32'h0;
					end
				end
				if (st_r.ovl_cnt >= 32'(OVERLOAD_CYC)) begin
					st_nxt.mode = conv_pkg::ST_RESTART;
					st_nxt.gate = 1'b0;
					st_nxt.wait_cnt = '0;
				end else if (st_r.gate && trip) begin
					st_nxt.gate = 1'b0;
				end else if (period_start && st_r.mode == conv_pkg::ST_RUN &&
					lp.burst_level) begin
					st_nxt.gate = 1'b1;
				end else if (st_r.mode == conv_pkg::ST_BURST) begin
					st_nxt.gate = st_r.gate && !trip;
				end
				st_nxt.charger = !aux_winding_sel &&
					sup.charger_on_level &&
					!sup.supply_start_level && !st_nxt.gate;
				if (aux_winding_sel && !sup.charger_on_level) begin
					st_nxt.charger = !sup.supply_start_level && !st_nxt.gate;
				end
			end
		endcase
		if (!sup.supply_stop_level && st_r.mode != conv_pkg::ST_LOCKOUT) begin
			st_nxt.mode = conv_pkg::ST_LOCKOUT;
			st_nxt.gate = 1'b0;
			st_nxt.charger = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{mode: conv_pkg::ST_LOCKOUT, gate: 1'b0, charger: 1'b0,
				on_cnt: 5'h00, limit_hit: 1'b0,
				ovl_cnt: 32'h0, wait_cnt: 32'h0, ss_cnt: 32'h0,
				ss_level: 4'h0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign gate_drive = st_r.gate;
	assign charger_enable = st_r.charger;
	assign feedback_pullup_en = 1'b1;
	assign burst_limit_sel = (st_r.mode == conv_pkg::ST_BURST);
	// The analog limit is the lower of this code and the limit pin setting.
	assign current_limit_level = st_r.ss_level;
	assign mode = st_r.mode;
	assign overload_stop = (st_r.mode == conv_pkg::ST_RESTART);

	// ****************************************************************
	// Checks
	// ****************************************************************
	lockout_gate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		st_r.mode == conv_pkg::ST_LOCKOUT |=> !gate_drive)
		else $error("gate driven during lockout");
	start_charger_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		st_r.mode == conv_pkg::ST_LOCKOUT && st_nxt.mode == conv_pkg::ST_RUN
		|=> !charger_enable && current_limit_level == 4'h0)
		else $error("charger left on at start");
	stop_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		!sup.supply_stop_level |=> mode == conv_pkg::ST_LOCKOUT)
		else $error("activity after supply stop");
	burst_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		mode == conv_pkg::ST_BURST && !gate_drive |=> !gate_drive ||
		mode != conv_pkg::ST_BURST)
		else $error("switch turned on in burst idle");
	blank_min_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		st_r.gate && !blank_done && sup.supply_stop_level &&
		st_r.ovl_cnt < 32'(OVERLOAD_CYC) |=> gate_drive)
		else $error("on-time shorter than minimum");
	overload_stop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		run_mode && st_r.ovl_cnt >= 32'(OVERLOAD_CYC) && sup.supply_stop_level
		|=> overload_stop && !gate_drive)
		else $error("no stop at overload trip");
	charger_off_time_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		run_mode && gate_drive |-> !charger_enable)
		else $error("charger on during on-time");
	burst_limit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		burst_limit_sel |-> mode == conv_pkg::ST_BURST)
		else $error("burst limit outside burst");

	sequence restart_hold_s;
		st_r.mode == conv_pkg::ST_RESTART && sup.supply_stop_level &&
		st_r.wait_cnt < 32'(RESTART_CYC) - 32'h1;
	endsequence

	sequence restart_done_s;
		st_r.mode == conv_pkg::ST_RESTART &&
		st_nxt.mode == conv_pkg::ST_RUN;
	endsequence

	sequence burst_stay_s;
		st_r.mode == conv_pkg::ST_BURST && !lp.burst_hysteresis &&
		sup.supply_stop_level && st_r.ovl_cnt < 32'(OVERLOAD_CYC);
	endsequence

	restart_wait_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		restart_hold_s |=> overload_stop && !gate_drive)
		else $error("restart wait ended early");
	restart_ss_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		restart_done_s |=> current_limit_level == 4'h0 &&
		st_r.ovl_cnt == 32'h0)
		else $error("restart without soft-start");
	burst_stay_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		burst_stay_s |=> mode == conv_pkg::ST_BURST)
		else $error("burst left below hysteresis level");
	burst_entry_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		st_r.mode == conv_pkg::ST_RUN && !lp.burst_level &&
		sup.supply_stop_level && st_r.ovl_cnt < 32'(OVERLOAD_CYC)
		|=> mode == conv_pkg::ST_BURST)
		else $error("no burst entry below burst level");
	trip_off_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		st_r.gate && blank_done &&
		(lp.pwm_trip || lp.overcurrent_comparator) |=> !gate_drive)
		else $error("switch left on after comparator trip");
	period_set_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		period_start && st_r.mode == conv_pkg::ST_RUN && !st_r.gate &&
		lp.burst_level && sup.supply_stop_level &&
		st_r.ovl_cnt < 32'(OVERLOAD_CYC) |=> gate_drive)
		else $error("switch not set at period start");
	ovl_down_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		run_mode && period_start && !st_r.limit_hit && st_r.ovl_cnt != 32'h0
		|=> st_r.ovl_cnt < $past(st_r.ovl_cnt))
		else $error("overload counter not counting down");
	ovl_up_a: assert property (@(posedge core_clk)
		disable iff (!reset_n)
		run_mode && period_start && st_r.limit_hit
		|=> st_r.ovl_cnt > $past(st_r.ovl_cnt))
		else $error("overload counter not counting up");

endmodule

//--- conv_pkg.sv
// Shared constants and carrier types for the converter control core.
package conv_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned FREQ_LOW_HZ = 60000;
	localparam int unsigned FREQ_HIGH_HZ = 115000;
	localparam int unsigned DEV_LOW_HZ = 4000;
	localparam int unsigned DEV_HIGH_HZ = 8000;
	localparam int unsigned JITTER_HZ = 230;
	localparam int unsigned MIN_ON_NS = 450;
	localparam int unsigned SOFTSTART_US = 8500;
	localparam int unsigned OVERLOAD_MS = 50;
	localparam int unsigned RESTART_MS = 1000;
	localparam int unsigned PERIOD_LOW_CYC = CLK_HZ / FREQ_LOW_HZ;
	localparam int unsigned PERIOD_HIGH_CYC = CLK_HZ / FREQ_HIGH_HZ;
	localparam int unsigned DEV_LOW_CYC =
		CLK_HZ / (FREQ_LOW_HZ - DEV_LOW_HZ) - PERIOD_LOW_CYC;
	localparam int unsigned DEV_HIGH_CYC =
		CLK_HZ / (FREQ_HIGH_HZ - DEV_HIGH_HZ) - PERIOD_HIGH_CYC;
	localparam int unsigned MIN_ON_CYC = (MIN_ON_NS * 20 + 999) / 1000;
	localparam int unsigned JITTER_STEP_CYC = CLK_HZ / JITTER_HZ;
	localparam int unsigned SOFTSTART_CYC = SOFTSTART_US * (CLK_HZ / 1000000);
	localparam int unsigned OVERLOAD_CYC = OVERLOAD_MS * (CLK_HZ / 1000);
	localparam int unsigned RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
	localparam int unsigned LIMIT_STEPS = 16;
	localparam logic [3:0] LIMIT_FULL = 4'hf;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic supply_start_level;
		logic supply_stop_level;
		logic charger_on_level;
		logic drain_start_level;
	} supply_cmp_t;

	typedef struct packed {
		logic pwm_trip;
		logic overcurrent_comparator;
		logic limit_set_open;
		logic comp_upper_level;
		logic burst_level;
		logic burst_hysteresis;
	} loop_cmp_t;

	typedef enum logic [1:0] {
		ST_LOCKOUT = 2'b00,
		ST_RUN = 2'b01,
		ST_BURST = 2'b10,
		ST_RESTART = 2'b11
	} mode_t;

endpackage

//--- conv_sync.sv
// Two flip-flop synchroniser for a group of asynchronous comparator levels.
module conv_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;

endmodule

//--- conv_osc.sv
// Jittered fixed-frequency oscillator producing a period-start pulse.
module conv_osc #(
	parameter int unsigned PERIOD_LOW = conv_pkg::PERIOD_LOW_CYC,
	parameter int unsigned PERIOD_HIGH = conv_pkg::PERIOD_HIGH_CYC,
	parameter int unsigned DEV_LOW = conv_pkg::DEV_LOW_CYC,
	parameter int unsigned DEV_HIGH = conv_pkg::DEV_HIGH_CYC,
	parameter int unsigned JIT_STEP = conv_pkg::JITTER_STEP_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Control
	input wire logic high_freq_sel,
	// Output
	output logic period_start,
	output logic [9:0] period_len
);

	typedef struct packed {
		logic [9:0] cnt;
		logic [17:0] jit_cnt;
		logic [4:0] jit_pos;
		logic jit_up;
		logic [9:0] len;
	} osc_state_t;

	osc_state_t st_r;
	osc_state_t st_nxt;
	logic [9:0] base;
	logic [9:0] dev;
	logic [14:0] prod;

	// The period is swept as a triangle across 32 steps per jitter cycle,
	// so the spread is about twice the single-sided deviation.
	always_comb begin
		base = high_freq_sel ? 10'(PERIOD_HIGH) : 10'(PERIOD_LOW);
		dev = high_freq_sel ? 10'(DEV_HIGH) : 10'(DEV_LOW);
		prod = 15'(dev) * 15'(st_r.jit_pos);
		st_nxt = st_r;
		if (st_r.jit_cnt >= 18'(JIT_STEP / 32 - 1)) begin
			st_nxt.jit_cnt = '0;
			if (st_r.jit_up && st_r.jit_pos == 5'h0f) begin
				st_nxt.jit_up = 1'b0;
			end else if (!st_r.jit_up && st_r.jit_pos == 5'h00) begin
				st_nxt.jit_up = 1'b1;
			end
			st_nxt.jit_pos = (st_nxt.jit_up == st_r.jit_up) ?
				(st_r.jit_up ? st_r.jit_pos + 5'h01 : st_r.jit_pos - 5'h01) :
				st_r.jit_pos;
		end else begin
			st_nxt.jit_cnt = st_r.jit_cnt + 18'h00001;
		end
		st_nxt.len = base - dev + 10'((prod >> 3) & 15'h03ff);
		if (st_r.cnt >= st_r.len - 10'h001) begin
			st_nxt.cnt = '0;
		end else begin
			st_nxt.cnt = st_r.cnt + 10'h001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{cnt: 10'h000, jit_cnt: 18'h00000, jit_pos: 5'h00,
				jit_up: 1'b1, len: 10'(PERIOD_LOW)};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign period_start = (st_r.cnt == 10'h000);
	assign period_len = st_r.len;

endmodule

//--- conv_stage_model.sv
// Power stage model that turns the gate into comparator levels.
module conv_stage_model (
	// Clock
	input wire logic core_clk,
	// Stage control
	input wire logic gate_drive,
	input wire logic overload,
	input wire logic [7:0] trip_after,
	input wire logic [1:0] comp_code,
	// Comparators
	output conv_pkg::loop_cmp_t loop_cmp
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Drain current ramp
	// ****************************************************************
	logic [7:0] on_cnt = 8'h00;

	// The trip stands until the switch opens, as the real current would.
	always @(posedge core_clk) begin
		if (!gate_drive)
			on_cnt <= 8'h00;
		else if (on_cnt != 8'hff)
			on_cnt <= on_cnt + 8'h01;
	end

	always_comb begin
		loop_cmp.pwm_trip = gate_drive && !overload && on_cnt >= trip_after;
		loop_cmp.overcurrent_comparator =
			gate_drive && overload && on_cnt >= trip_after;
		loop_cmp.limit_set_open = 1'b1;
		loop_cmp.comp_upper_level = comp_code == 2'h3;
		loop_cmp.burst_level = comp_code != 2'h0;
		loop_cmp.burst_hysteresis = comp_code[1];
	end
endmodule

//--- conv_ctrl_tb.sv
// Self-checking testbench for the converter control core.
module conv_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SS = 2000;
	localparam int OVL = 3000;
	localparam int RST = 5000;
	localparam int LIMIT = 85000;
	localparam int MON = int'(conv_pkg::MIN_ON_CYC);
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic high_freq_sel = 1'b0;
	logic aux_winding_sel = 1'b0;
	logic overload = 1'b0;
	logic [7:0] trip_after = 8'h03;
	logic [1:0] comp_code = 2'h2;
	conv_pkg::supply_cmp_t sup = '0;
	conv_pkg::loop_cmp_t loop_cmp;
	logic gate_drive;
	logic charger_enable;
	logic feedback_pullup_en;
	logic burst_limit_sel;
	logic overload_stop;
	logic [3:0] current_limit_level;
	conv_pkg::mode_t mode;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int last_rise, rises, per_min, per_max, on_len, on_min, n;
	logic gate_q = 1'b0;
	logic chg_seen, ovl_seen, gate_bad, overlap;

	always #25 core_clk = ~core_clk;

	conv_ctrl #(.SOFTSTART_CYC(SS), .OVERLOAD_CYC(OVL), .RESTART_CYC(RST),
		.JIT_STEP(400)) u_conv_ctrl (
		.core_clk(core_clk), .reset_n(reset_n),
		.high_freq_sel(high_freq_sel), .aux_winding_sel(aux_winding_sel),
		.supply_cmp(sup), .loop_cmp(loop_cmp), .gate_drive(gate_drive),
		.charger_enable(charger_enable),
		.feedback_pullup_en(feedback_pullup_en),
		.burst_limit_sel(burst_limit_sel),
		.current_limit_level(current_limit_level), .mode(mode),
		.overload_stop(overload_stop)
	);

	conv_stage_model u_conv_stage_model (
		.core_clk(core_clk), .gate_drive(gate_drive), .overload(overload),
		.trip_after(trip_after), .comp_code(comp_code), .loop_cmp(loop_cmp)
	);

	// ****************************************************************
	// Monitor
	// ****************************************************************
	// Sampling on the falling edge keeps clear of the design's updates.
	always @(negedge core_clk) begin
		cyc++;
		if (gate_drive && !gate_q) begin
			if (rises > 0 && cyc - last_rise < per_min)
				per_min = cyc - last_rise;
			if (rises > 0 && cyc - last_rise > per_max)
				per_max = cyc - last_rise;
			rises++;
			last_rise = cyc;
		end
		if (!gate_drive && gate_q && on_len < on_min)
			on_min = on_len;
		on_len = gate_drive ? on_len + 1 : 0;
		gate_q = gate_drive;
		chg_seen |= charger_enable;
		ovl_seen |= overload_stop;
		overlap |= gate_drive & charger_enable;
		gate_bad |= gate_drive & (overload_stop |
			(mode == conv_pkg::ST_LOCKOUT));
		if (cyc > LIMIT) begin
			bad_count++;
			$display("ERROR t=%0t cycles=%h limit=%h", $time, cyc, LIMIT);
			print_verdict();
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic bad(int got, int exp);
		bad_count++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	endtask

	task automatic chk_bit(logic got, logic exp);
		cmp_count++;
		if (got !== exp)
			bad(got, exp);
	endtask

	task automatic chk_mode(conv_pkg::mode_t got, conv_pkg::mode_t exp);
		cmp_count++;
		if (got !== exp)
			bad(got, exp);
	endtask

	task automatic chk_lvl(logic [3:0] got, logic [3:0] exp);
		cmp_count++;
		if (got !== exp)
			bad(got, exp);
	endtask

	task automatic chk_range(int got, int lo, int hi);
		cmp_count++;
		if (got < lo || got > hi)
			bad(got, got < lo ? lo : hi);
	endtask

	task automatic clr();
		rises = 0;
		per_min = 100000;
		per_max = 0;
		on_min = 100000;
		{chg_seen, ovl_seen, gate_bad, overlap} = 4'h0;
	endtask

	task automatic wait_mode(conv_pkg::mode_t m, int limit_set_pin);
		n = 0;
		while (mode !== m && n < limit_set_pin) begin
			@(negedge core_clk);
			n++;
		end
		chk_mode(mode, m);
	endtask

	task automatic wait_stop(int limit_set_pin);
		n = 0;
		while (overload_stop !== 1'b1 && n < limit_set_pin) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_power_up();
		chk_bit(gate_drive, 1'b0);
		chk_bit(feedback_pullup_en, 1'b1);
		@(posedge core_clk);
		sup <= 4'h5;
		repeat (6) @(negedge core_clk);
		chk_bit(charger_enable, 1'b1);
		chk_mode(mode, conv_pkg::ST_LOCKOUT);
		@(posedge core_clk);
		sup <= 4'hf;
		clr();
		wait_mode(conv_pkg::ST_RUN, 5);
		chk_bit(charger_enable, 1'b0);
		chk_lvl(current_limit_level, 4'h0);
		repeat (SS / 4) @(negedge core_clk);
		chk_bit(current_limit_level == conv_pkg::LIMIT_FULL, 1'b0);
		repeat (SS) @(negedge core_clk);
		chk_lvl(current_limit_level, conv_pkg::LIMIT_FULL);
		chk_range(on_min, MON, MON + 6);
		chk_bit(gate_bad, 1'b0);
		$display("power-up test done");
	endtask

	task automatic t_freq(logic sel, int p, int d);
		@(posedge core_clk);
		high_freq_sel <= sel;
		repeat (500) @(negedge core_clk);
		clr();
		repeat (13000) @(negedge core_clk);
		chk_range(per_min, p - d - 1, p + d + 1);
		chk_range(per_max, p - d - 1, p + d + 1);
		chk_range(per_max - per_min, 2, 2 * d + 2);
		$display("frequency test done");
	endtask

	task automatic t_charger();
		@(posedge core_clk);
		sup.supply_start_level <= 1'b0;
		clr();
		repeat (2000) @(negedge core_clk);
		chk_bit(chg_seen, 1'b1);
		chk_bit(overlap, 1'b0);
		chk_mode(mode, conv_pkg::ST_RUN);
		@(posedge core_clk);
		aux_winding_sel <= 1'b1;
		repeat (5) @(negedge core_clk);
		clr();
		repeat (1000) @(negedge core_clk);
		chk_bit(chg_seen, 1'b0);
		@(posedge core_clk);
		aux_winding_sel <= 1'b0;
		sup.supply_start_level <= 1'b1;
		$display("charger test done");
	endtask

	task automatic t_burst();
		@(posedge core_clk);
		comp_code <= 2'h0;
		wait_mode(conv_pkg::ST_BURST, 5);
		chk_bit(burst_limit_sel, 1'b1);
		@(negedge core_clk);
		clr();
		@(posedge core_clk);
		comp_code <= 2'h1;
		repeat (1000) @(negedge core_clk);
		chk_range(rises, 0, 0);
		chk_mode(mode, conv_pkg::ST_BURST);
		@(posedge core_clk);
		comp_code <= 2'h3;
		wait_mode(conv_pkg::ST_RUN, 5);
		chk_bit(burst_limit_sel, 1'b0);
		$display("burst test done");
	endtask

	task automatic t_overload();
		@(posedge core_clk);
		overload <= 1'b1;
		clr();
		wait_stop(OVL + 1000);
		chk_range(n, OVL - 400, OVL + 800);
		wait_mode(conv_pkg::ST_RUN, RST + 100);
		chk_range(n, RST - 10, RST + 10);
		chk_bit(gate_bad, 1'b0);
		chk_lvl(current_limit_level, 4'h0);
		wait_stop(OVL + 1000);
		chk_range(n, OVL - 400, OVL + 800);
		@(posedge core_clk);
		overload <= 1'b0;
		wait_mode(conv_pkg::ST_RUN, RST + 100);
		repeat (SS + 100) @(negedge core_clk);
		@(posedge core_clk);
		overload <= 1'b1;
		repeat (OVL / 2) @(negedge core_clk);
		@(posedge core_clk);
		overload <= 1'b0;
		clr();
		repeat (OVL) @(negedge core_clk);
		chk_bit(ovl_seen, 1'b0);
		@(posedge core_clk);
		overload <= 1'b1;
		wait_stop(OVL + 1000);
		chk_range(n, OVL - 400, OVL + 800);
		@(posedge core_clk);
		overload <= 1'b0;
		wait_mode(conv_pkg::ST_RUN, RST + 100);
		$display("overload test done");
	endtask

	task automatic t_power_down();
		@(posedge core_clk);
		sup <= 4'h1;
		wait_mode(conv_pkg::ST_LOCKOUT, 5);
		repeat (3) @(negedge core_clk);
		chk_bit(gate_drive, 1'b0);
		@(posedge core_clk);
		sup <= 4'hf;
		wait_mode(conv_pkg::ST_RUN, 5);
		chk_lvl(current_limit_level, 4'h0);
		$display("power-down test done");
	endtask

	initial begin
		clr();
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk);
		t_power_up();
		t_freq(1'b0, int'(conv_pkg::PERIOD_LOW_CYC), int'(conv_pkg::DEV_LOW_CYC));
		t_freq(1'b1, int'(conv_pkg::PERIOD_HIGH_CYC),
			int'(conv_pkg::DEV_HIGH_CYC));
		t_charger();
		t_burst();
		t_overload();
		t_power_down();
		print_verdict();
	end
endmodule
